/* logic/svlr_pkg.sv */
// Purpose: Shared constants and types of the serial video link receiver output block.
// Assumes: 10 MHz mclk; one forward symbol per link clock period.
// Notes: Register offsets and field positions are byte-wide control registers.
package svlr_pkg;
  // Clocking
  localparam int MCLK_HZ = 10_000_000;
  localparam int BACK_RATE_BPS = 10_000_000;
  localparam int BACK_BIT_CYC = MCLK_HZ / BACK_RATE_BPS;
  // Stream-stop timeout: no rising link clock edge for this long means the stream stopped
  localparam int STOP_TIME_NS = 4000;
  localparam int STOP_CYC = STOP_TIME_NS * (MCLK_HZ / 1_000_000) / 1000;

  // Register offsets
  localparam logic [7:0] REG_GEN_CFG = 8'h02;
  localparam logic [7:0] REG_CABLE = 8'h1c;
  localparam logic [7:0] REG_SPREAD = 8'h2c;
  localparam logic [7:0] REG_ERRCNT = 8'h41;
  // General configuration fields
  localparam int GEN_FILT_BIT = 0;
  localparam int GEN_EDGE_BIT = 1;
  localparam int GEN_LF_BIT = 2;
  localparam int GEN_LEGACY_BIT = 3;
  localparam int GEN_OSC_EN_BIT = 5;
  localparam int GEN_OSC_SEL_LSB = 6;
  localparam logic [7:0] GEN_CFG_RST = 8'h03;
  // Spread configuration fields
  localparam int SPREAD_EN_BIT = 3;
  localparam logic [7:0] SPREAD_CFG_RST = 8'h00;
  // Status fields
  localparam int CABLE_OK_BIT = 0;
  localparam int CABLE_LOCK_BIT = 1;

  // Symbol layout, 35-bit normal and 28-bit legacy
  localparam int SYM_W = 35;
  localparam int PIX_W = 24;
  localparam int SYM_CLK1_BIT = 34;
  localparam int SYM_CLK0_BIT = 0;
  localparam int SYM_PIX_LSB = 10;
  localparam int SYM_AV_BIT = 9;
  localparam int SYM_LS_BIT = 8;
  localparam int SYM_FS_BIT = 7;
  localparam int LEG_CLK_BIT = 27;
  localparam int LEG_PIX_LSB = 3;
  localparam int LEG_AV_BIT = 2;
  localparam int LEG_LS_BIT = 1;
  localparam int LEG_FS_BIT = 0;

  // Counts
  localparam logic [4:0] ERR_MAX = 5'h1f;
  localparam logic [1:0] FILT_MIN_SYMS = 2'h3;
  localparam logic [2:0] LOCK_SYMS = 3'h4;
  localparam int OSC_HALF_UNIT = 4;
  localparam int BACK_FRAME_W = 8;
  // Modulation period in symbols for each range and setting half
  localparam logic [11:0] FMOD_DIV_HF_LO = 12'd2168;
  localparam logic [11:0] FMOD_DIV_HF_HI = 12'd1300;
  localparam logic [11:0] FMOD_DIV_LF_LO = 12'd628;
  localparam logic [11:0] FMOD_DIV_LF_HI = 12'd388;
  // Output clock delay line; taps below SSC_BASE_TAP give the data time to settle
  localparam int SSC_TAPS = 6;
  localparam int SSC_BASE_TAP = 2;

  typedef enum logic [1:0] {ST_DOWN, ST_ACQUIRE, ST_LOCKED, ST_SLEEP} svlr_lstate_e;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
    logic activeVideo;
    logic lineSync;
    logic frameSync;
  } svlr_pix_s;
endpackage

/* logic/svlr_sync3.sv */
// Purpose: Three-flop synchroniser for inputs from outside the mclk domain.
// Assumes: A change is taken once the second and third stages agree.
// Notes: The first stage feeds only the second.
`timescale 1ns/1ps
`default_nettype none
module svlr_sync3 #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } svlr_sync_s;

  svlr_sync_s st_ff;
  svlr_sync_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = din;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st_ff.s2[i] == st_ff.s3[i]) begin
        nxt_st.q[i] = st_ff.s3[i];
      end
    end
    if (sys_rst) begin
      nxt_st = '0;
    end
  end

  always_ff @(posedge mclk) begin
    st_ff <= nxt_st;
  end

  assign dout = st_ff.q;
endmodule
`default_nettype wire

/* logic/svlr_glitch_filt.sv */
// Purpose: Per-symbol glitch filter for one video control signal.
// Assumes: stb marks one received symbol.
// Notes: With filtOn low every change passes at the next symbol.
`timescale 1ns/1ps
`default_nettype none
module svlr_glitch_filt
  import svlr_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic stb,
  input wire logic filtOn,
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic q;
    logic [1:0] cnt;
  } svlr_filt_s;

  svlr_filt_s st_ff;
  svlr_filt_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (stb) begin
      if (din == st_ff.q) begin
        nxt_st.cnt = 2'h0;
      end else if (filtOn && st_ff.cnt != FILT_MIN_SYMS - 2'h1) begin
        nxt_st.cnt = st_ff.cnt + 2'h1;
      end else begin
        nxt_st.q = din;
        nxt_st.cnt = 2'h0;
      end
    end
    if (sys_rst) begin
      nxt_st = '0;
    end
  end

  always_ff @(posedge mclk) begin
    st_ff <= nxt_st;
  end

  assign dout = st_ff.q;
endmodule
`default_nettype wire

/* logic/svlr_receiver.sv */
// Purpose: Receive side of a serial video link: symbol deframing, lock, parallel pixel output.
// Assumes: Link clock and symbol word arrive on pins; symbol word changes on the link clock fall.
// Notes: Pixel rate in simulation is far below the mclk rate; spread and stagger are in mclk steps.
//
// How it works
// - Each link symbol carries 35 bits: pixel, syncs, control and audio.
// - Pixel clock 5 to 85 MHz recovered from the stream, no local reference.
// - Return channel sends control bit, CRC and four GPIO bits at 10 Mbps.
// - Legacy mode accepts 28-bit symbols from older serializers, 15 to 65 MHz.
// - Filter on, normal mode: active video and line sync pulses under 3 symbols rejected.
// - Filter off: no minimum pulse width; source still limits transitions.
// - Spread enabled by register modulates output clock and data together.
// - High range: settings give three depths at PCLK/2168 or PCLK/1300.
// - Low range: settings give three depths at PCLK/628 or PCLK/388.
// - Red, green and blue groups switch at staggered times.
// - Power-down input low disables the link and holds outputs quiet.
// - Stopped stream gives sleep, registers kept, relock on return.
// - Any cable fault clears the cable-detected status bit.
// - Link errors counted in five bits of the error count register.
// - Oscillator enable drives the output clock from an oscillator when stream lost.
// - Edge select high launches data on rising clock edge, low on falling.
// - Lock without training; embedded clock bits checked before each symbol is used.
// - After power-down release, lock is raised once valid symbols are recovered.
// - Low range setting takes effect only through a power-down.
`timescale 1ns/1ps
`default_nettype none
module svlr_receiver
  import svlr_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic powerDownN,
  input wire logic linkClk,
  input wire logic [SYM_W-1:0] linkSym,
  input wire logic cableFault,
  input wire logic [3:0] gpioIn,
  input wire logic [7:0] regAddr,
  input wire logic regWe,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  output logic pixClkOut,
  output svlr_pix_s pixOut,
  output logic lockOut,
  output logic backTx
);
  typedef struct packed {
    svlr_lstate_e lstate;
    logic [7:0] genCfg;
    logic [7:0] spreadCfg;
    logic lfActive;
    logic clkPrev;
    logic [SYM_W-1:0] sym;
    logic symStb;
    logic [2:0] lockCnt;
    logic [5:0] idleCnt;
    logic [4:0] errCnt;
    svlr_pix_s stage;
    svlr_pix_s pix;
    logic [1:0] launchDly;
    logic [SSC_TAPS-1:0] clkDly;
    logic [11:0] modPhase;
    logic [1:0] sscOff;
    logic sscDown;
    logic oscClk;
    logic [4:0] oscCnt;
    logic pixClk;
    logic [BACK_FRAME_W-1:0] backSh;
    logic [2:0] backCnt;
    logic backBit;
    logic [7:0] rdData;
    logic lock;
  } svlr_core_s;

  svlr_core_s st_ff;
  svlr_core_s nxt_st;
  logic [2:0] ctlSync;
  logic [SYM_W-1:0] symSync;
  logic avFilt;
  logic lsFilt;
  logic pdn;
  logic clkS;
  logic clkRise;
  logic legacy;
  logic filtOn;
  logic avRaw;
  logic lsRaw;

  svlr_sync3 #(.WIDTH(3)) u_ctl_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .din({powerDownN, cableFault, linkClk}),
    .dout(ctlSync)
  );

  svlr_sync3 #(.WIDTH(SYM_W)) u_sym_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .din(linkSym),
    .dout(symSync)
  );

  assign pdn = ctlSync[2];
  assign clkS = ctlSync[0];
  assign clkRise = clkS & ~st_ff.clkPrev;
  assign legacy = st_ff.genCfg[GEN_LEGACY_BIT];
  // Filter applies to normal mode only
  assign filtOn = st_ff.genCfg[GEN_FILT_BIT] & ~legacy;
  assign avRaw = legacy ? symSync[LEG_AV_BIT] : symSync[SYM_AV_BIT];
  assign lsRaw = legacy ? symSync[LEG_LS_BIT] : symSync[SYM_LS_BIT];

  svlr_glitch_filt u_av_filt (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .stb(clkRise),
    .filtOn(filtOn),
    .din(avRaw),
    .dout(avFilt)
  );

  svlr_glitch_filt u_ls_filt (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .stb(clkRise),
    .filtOn(filtOn),
    .din(lsRaw),
    .dout(lsFilt)
  );

  // Symbols per offset step so one up-down sweep spans the modulation period
  function automatic logic [11:0] step_len(input logic [11:0] div, input logic [1:0] depth);
    logic [11:0] r;
    r = div >> 1;
    if (depth == 2'h2) begin
      r = div >> 2;
    end else if (depth == 2'h3) begin
      r = 12'(div / 12'd6);
    end
    return r;
  endfunction

  // Two-bit check over the return payload, polynomial x^2+x+1
  function automatic logic [1:0] crc2(input logic [4:0] d);
    logic [1:0] c;
    c = 2'h0;
    for (int i = 4; i >= 0; i--) begin
      c = {c[0] ^ d[i] ^ c[1], d[i] ^ c[1]};
    end
    return c;
  endfunction

  logic symValid;
  logic [11:0] modDiv;
  logic [1:0] sscDepth;
  logic [2:0] tap;
  logic clkTap;
  logic launch;
  logic [4:0] oscHalf;
  logic oscMode;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.clkPrev = clkS;
    nxt_st.symStb = 1'b0;
    nxt_st.launchDly = {st_ff.launchDly[0], 1'b0};
    nxt_st.clkDly = {st_ff.clkDly[SSC_TAPS-2:0], clkS};

    symValid = legacy ? st_ff.sym[LEG_CLK_BIT]
                      : (st_ff.sym[SYM_CLK1_BIT] & ~st_ff.sym[SYM_CLK0_BIT]);

    // Register writes; a counter clear is applied before a same-cycle error below
    if (regWe) begin
      unique case (regAddr)
        REG_GEN_CFG: nxt_st.genCfg = regWrData;
        REG_SPREAD: nxt_st.spreadCfg = regWrData;
        REG_ERRCNT: nxt_st.errCnt = 5'h0;
        default: ;
      endcase
    end

    if (clkRise) begin
      nxt_st.sym = symSync;
      nxt_st.symStb = 1'b1;
      nxt_st.idleCnt = 6'h0;
    end else if (st_ff.idleCnt != 6'(STOP_CYC)) begin
      nxt_st.idleCnt = st_ff.idleCnt + 6'h1;
    end

    unique case (st_ff.lstate)
      ST_DOWN: begin
        if (pdn) begin
          nxt_st.lstate = ST_ACQUIRE;
        end
      end
      ST_ACQUIRE, ST_LOCKED: begin
        if (st_ff.idleCnt == 6'(STOP_CYC)) begin
          nxt_st.lstate = ST_SLEEP;
          nxt_st.lockCnt = 3'h0;
        end else if (st_ff.symStb && !symValid) begin
          // saturate at 31
          // Counts on from the cleared value, so a same-cycle clear leaves one
          if (nxt_st.errCnt != ERR_MAX) begin
            nxt_st.errCnt = nxt_st.errCnt + 5'h1;
          end else begin
            nxt_st.errCnt = ERR_MAX;
          end
          nxt_st.lockCnt = 3'h0;
          nxt_st.lstate = ST_ACQUIRE;
        end else if (st_ff.symStb && st_ff.lstate == ST_ACQUIRE) begin
          nxt_st.lockCnt = st_ff.lockCnt + 3'h1;
          if (st_ff.lockCnt == LOCK_SYMS - 3'h1) begin
            nxt_st.lstate = ST_LOCKED;
          end
        end
      end
      ST_SLEEP: begin
        if (clkRise) begin
          nxt_st.lstate = ST_ACQUIRE;
        end
      end
    endcase

    // Pixel word staged one cycle after the symbol, with filtered active video and line sync and raw frame sync
    if (st_ff.symStb && symValid) begin
      if (legacy) begin
        {nxt_st.stage.red, nxt_st.stage.green, nxt_st.stage.blue} =
          st_ff.sym[LEG_PIX_LSB +: PIX_W];
        nxt_st.stage.frameSync = st_ff.sym[LEG_FS_BIT];
      end else begin
        {nxt_st.stage.red, nxt_st.stage.green, nxt_st.stage.blue} =
          st_ff.sym[SYM_PIX_LSB +: PIX_W];
        nxt_st.stage.frameSync = st_ff.sym[SYM_FS_BIT];
      end
      nxt_st.stage.activeVideo = avFilt;
      nxt_st.stage.lineSync = lsFilt;
    end

    if (st_ff.lfActive) begin
      modDiv = st_ff.spreadCfg[2] ? FMOD_DIV_LF_HI : FMOD_DIV_LF_LO;
    end else begin
      modDiv = st_ff.spreadCfg[2] ? FMOD_DIV_HF_HI : FMOD_DIV_HF_LO;
    end
    // Deviation grows with the low setting bits; three taps is the deepest the
    // symbol period allows before a falling launch would overrun the next symbol
    sscDepth = (st_ff.spreadCfg[1:0] == 2'h0) ? 2'h1 :
               (st_ff.spreadCfg[1:0] == 2'h3) ? 2'h3 : 2'h2;
    if (!st_ff.spreadCfg[SPREAD_EN_BIT]) begin
      nxt_st.sscOff = 2'h0;
      nxt_st.sscDown = 1'b0;
      nxt_st.modPhase = 12'h0;
    end else if (st_ff.symStb) begin
      if (st_ff.modPhase >= step_len(modDiv, sscDepth) - 12'h1) begin
        nxt_st.modPhase = 12'h0;
        if (st_ff.sscDown) begin
          nxt_st.sscOff = st_ff.sscOff - 2'h1;
          nxt_st.sscDown = (st_ff.sscOff != 2'h1);
        end else begin
          nxt_st.sscOff = st_ff.sscOff + 2'h1;
          nxt_st.sscDown = (st_ff.sscOff + 2'h1 >= sscDepth);
        end
      end else begin
        nxt_st.modPhase = st_ff.modPhase + 12'h1;
      end
    end
    tap = 3'(SSC_BASE_TAP) + {1'b0, st_ff.sscOff};
    clkTap = st_ff.clkDly[tap];

    oscMode = st_ff.genCfg[GEN_OSC_EN_BIT] && st_ff.lstate != ST_LOCKED;
    oscHalf = 5'(OSC_HALF_UNIT) * ({3'h0, st_ff.genCfg[GEN_OSC_SEL_LSB +: 2]} + 5'h1);
    if (oscMode) begin
      if (st_ff.oscCnt >= oscHalf - 5'h1) begin
        nxt_st.oscCnt = 5'h0;
        nxt_st.oscClk = ~st_ff.oscClk;
      end else begin
        nxt_st.oscCnt = st_ff.oscCnt + 5'h1;
      end
    end else begin
      nxt_st.oscCnt = 5'h0;
      nxt_st.oscClk = 1'b0;
    end

    if (st_ff.lstate == ST_LOCKED) begin
      nxt_st.pixClk = clkTap;
    end else begin
      nxt_st.pixClk = oscMode & st_ff.oscClk;
    end

    launch = (st_ff.lstate == ST_LOCKED) &&
             (st_ff.genCfg[GEN_EDGE_BIT] ? (clkTap & ~st_ff.pixClk)
                                         : (~clkTap & st_ff.pixClk));
    if (launch) begin
      nxt_st.pix.red = st_ff.stage.red;
      nxt_st.pix.activeVideo = st_ff.stage.activeVideo;
      nxt_st.pix.lineSync = st_ff.stage.lineSync;
      nxt_st.pix.frameSync = st_ff.stage.frameSync;
      nxt_st.launchDly[0] = 1'b1;
    end
    if (st_ff.launchDly[0]) begin
      nxt_st.pix.green = st_ff.stage.green;
    end
    if (st_ff.launchDly[1]) begin
      nxt_st.pix.blue = st_ff.stage.blue;
    end
    // Data low whenever there is no lock, including oscillator mode
    if (st_ff.lstate != ST_LOCKED) begin
      nxt_st.pix = '0;
    end

    if (st_ff.symStb && st_ff.lstate != ST_DOWN) begin
      nxt_st.backSh = {1'b1, gpioIn, ~ctlSync[1],
                       crc2({gpioIn, ~ctlSync[1]})};
      nxt_st.backCnt = 3'(BACK_FRAME_W - 1);
      nxt_st.backBit = 1'b0;
    end else if (st_ff.backCnt != 3'h0 || st_ff.backSh != '0) begin
      nxt_st.backBit = st_ff.backSh[BACK_FRAME_W-1];
      nxt_st.backSh = {st_ff.backSh[BACK_FRAME_W-2:0], 1'b0};
      nxt_st.backCnt = (st_ff.backCnt != 3'h0) ? st_ff.backCnt - 3'h1 : 3'h0;
    end else begin
      nxt_st.backBit = 1'b0;
    end

    unique case (regAddr)
      REG_GEN_CFG: nxt_st.rdData = st_ff.genCfg;
      REG_CABLE: nxt_st.rdData = {6'h0, st_ff.lstate == ST_LOCKED, ~ctlSync[1]};
      REG_SPREAD: nxt_st.rdData = st_ff.spreadCfg;
      REG_ERRCNT: nxt_st.rdData = {3'h0, st_ff.errCnt};
      default: nxt_st.rdData = 8'h00;
    endcase

    if (!pdn) begin
      nxt_st.lstate = ST_DOWN;
      nxt_st.lockCnt = 3'h0;
      nxt_st.errCnt = 5'h0;
      nxt_st.pix = '0;
      nxt_st.pixClk = 1'b0;
      nxt_st.launchDly = 2'h0;
      nxt_st.backSh = '0;
      nxt_st.backCnt = 3'h0;
      nxt_st.backBit = 1'b0;
      nxt_st.lfActive = st_ff.genCfg[GEN_LF_BIT];
    end
    nxt_st.lock = (nxt_st.lstate == ST_LOCKED);

    if (sys_rst) begin
      nxt_st = '0;
      nxt_st.genCfg = GEN_CFG_RST;
      nxt_st.spreadCfg = SPREAD_CFG_RST;
    end
  end

  always_ff @(posedge mclk) begin
    st_ff <= nxt_st;
  end

  assign regRdData = st_ff.rdData;
  assign pixClkOut = st_ff.pixClk;
  assign pixOut = st_ff.pix;
  assign lockOut = st_ff.lock;
  assign backTx = st_ff.backBit;
endmodule
`default_nettype wire

/* verification/svlr_receiver_props.sv */
// Purpose: Port-level checks of the link receiver output block.
// Assumes: Single mclk domain, synchronous active-high reset.
// Notes: Cycle margins cover the three-flop input synchronisers.
`timescale 1ns/1ps
`default_nettype none
module svlr_receiver_props
  import svlr_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic powerDownN,
  input wire logic linkClk,
  input wire logic [SYM_W-1:0] linkSym,
  input wire logic cableFault,
  input wire logic [3:0] gpioIn,
  input wire logic [7:0] regAddr,
  input wire logic regWe,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  input wire logic pixClkOut,
  input wire svlr_pix_s pixOut,
  input wire logic lockOut,
  input wire logic backTx
);
  logic [7:0] pdLowCnt_ff, pdHighCnt_ff, idleCnt_ff, faultCnt_ff;
  logic linkPrev_ff;

  function automatic logic [7:0] inc(input logic [7:0] c);
    return (c == 8'hff) ? c : c + 8'h01;
  endfunction

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pdLowCnt_ff <= 8'h00;
      pdHighCnt_ff <= 8'h00;
      idleCnt_ff <= 8'h00;
      faultCnt_ff <= 8'h00;
      linkPrev_ff <= 1'b0;
    end else begin
      pdLowCnt_ff <= powerDownN ? 8'h00 : inc(pdLowCnt_ff);
      pdHighCnt_ff <= powerDownN ? inc(pdHighCnt_ff) : 8'h00;
      idleCnt_ff <= (linkClk != linkPrev_ff) ? 8'h00 : inc(idleCnt_ff);
      faultCnt_ff <= cableFault ? inc(faultCnt_ff) : 8'h00;
      linkPrev_ff <= linkClk;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence cfgWrite;
    regWe && regAddr == REG_GEN_CFG ##1 regAddr == REG_GEN_CFG;
  endsequence
  sequence errClear;
    regWe && regAddr == REG_ERRCNT ##1 regAddr == REG_ERRCNT;
  endsequence

  pd_quiet_a: assert property (
    pdLowCnt_ff >= 8'h0a |-> !lockOut && pixOut == '0 && !pixClkOut && !backTx)
    else $error("outputs active during power-down");
  cfg_readback_a: assert property (
    cfgWrite |=> (regRdData & 8'hef) == ($past(regWrData, 2) & 8'hef))
    else $error("config register readback wrong");
  err_clear_a: assert property (
    errClear |=> regRdData <= 8'h01)
    else $error("error counter not cleared by write");
  cable_fault_a: assert property (
    faultCnt_ff >= 8'h08 && regAddr == REG_CABLE |=> !regRdData[CABLE_OK_BIT])
    else $error("cable detected despite fault");
  sleep_unlock_a: assert property (
    idleCnt_ff >= 8'h30 |-> !lockOut)
    else $error("lock held with stream stopped");
  back_quiet_a: assert property (
    idleCnt_ff >= 8'h18 |-> !backTx)
    else $error("return channel active without symbols");
  stagger_groups_a: assert property (
    lockOut && $past(lockOut) |->
      !($changed(pixOut.red) && $changed(pixOut.green) && $changed(pixOut.blue)))
    else $error("all colour groups switched together");
  lock_after_pd_a: assert property (
    $rose(lockOut) |-> pdHighCnt_ff >= 8'h18)
    else $error("lock raised too soon after power-down");
endmodule

bind svlr_receiver svlr_receiver_props chk_u (.mclk, .sys_rst, .powerDownN, .linkClk,
  .linkSym, .cableFault, .gpioIn, .regAddr, .regWe, .regWrData, .regRdData, .pixClkOut,
  .pixOut, .lockOut, .backTx);
`default_nettype wire

/* verification/svlr_ser_model.sv */
// Purpose: Serializer stand-in driving link clock and symbol word.
// Assumes: One symbol per 800 ns link period, word changes on the clock fall.
// Notes: A stopped link holds the clock low and inverts the released word.
`timescale 1ns/1ps
`default_nettype none
module svlr_ser_model
  import svlr_pkg::*;
(
  input wire logic run,
  input wire logic [SYM_W-1:0] txWord,
  output logic linkClk,
  output logic [SYM_W-1:0] linkSym
);
  logic parked;
  initial begin
    linkClk = 1'b0;
    linkSym = '0;
    parked = 1'b1;
    // Offset keeps link edges clear of mclk edges
    #37;
    forever begin
      if (run) begin
        if (parked)
          linkSym = txWord;
        parked = 1'b0;
        #400 linkClk = 1'b1;
        #400 linkClk = 1'b0;
        linkSym = txWord;
      end else begin
        if (!parked)
          linkSym = ~linkSym;
        parked = 1'b1;
        #100;
      end
    end
  end
endmodule
`default_nettype wire

/* verification/testbench.sv */
// Purpose: Self-checking bench for the link receiver output block.
// Assumes: 10 MHz mclk; serializer model gives an 800 ns link period.
// Notes: Inputs change 1 ns after the rising mclk edge.
`timescale 1ns/1ps
`default_nettype none
module testbench import svlr_pkg::*;;
  localparam logic [23:0] PX = 24'h123456;
  localparam logic [SYM_W-1:0] GOOD = {1'b1, PX, 3'h0, 6'h00, 1'b0};
  localparam logic [SYM_W-1:0] BAD = {1'b0, PX, 3'h0, 6'h00, 1'b0};
  logic mclk, sys_rst, powerDownN, cableFault, regWe, run, linkClk, pixClkOut, lockOut, backTx;
  logic [3:0] gpioIn;
  logic [7:0] regAddr, regWrData, regRdData, rdVal;
  logic [SYM_W-1:0] txWord, linkSym;
  svlr_pix_s pixOut;
  int errCount, nTests, c;
  logic s;

  svlr_ser_model ser_u (.run(run), .txWord(txWord), .linkClk(linkClk), .linkSym(linkSym));
  svlr_receiver dut_u (.mclk(mclk), .sys_rst(sys_rst), .powerDownN(powerDownN),
    .linkClk(linkClk), .linkSym(linkSym), .cableFault(cableFault), .gpioIn(gpioIn),
    .regAddr(regAddr), .regWe(regWe), .regWrData(regWrData), .regRdData(regRdData),
    .pixClkOut(pixClkOut), .pixOut(pixOut), .lockOut(lockOut), .backTx(backTx));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    nTests++;
    if (got !== exp) begin
      errCount++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr = a;
    regWrData = d;
    regWe = 1'b1;
    tick(1);
    regWe = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a);
    regAddr = a;
    tick(1);
    rdVal = regRdData;
  endtask
  task automatic waitLock;
    c = 0;
    while (lockOut !== 1'b1 && c < 600) begin
      tick(1);
      c++;
    end
  endtask
  // Word w is taken for exactly n symbols, then back
  task automatic sendN(input logic [SYM_W-1:0] w, input int n, input logic [SYM_W-1:0] back);
    @(negedge linkClk);
    #1 txWord = w;
    repeat (n) @(negedge linkClk);
    #1 txWord = back;
    tick(1);
  endtask
  // Long watch keeps control toggles at most two per 130 symbols
  task automatic pulse(input int n, input logic [7:0] cfg);
    wr(REG_GEN_CFG, cfg);
    s = 1'b0;
    fork
      sendN({1'b1, PX, 3'h4, 6'h00, 1'b0}, n, GOOD);
      repeat (1100) begin
        tick(1);
        if (pixOut.activeVideo === 1'b1) s = 1'b1;
      end
    join
  endtask

  task automatic t_regs;
    rd(REG_GEN_CFG); chk("gen cfg reset", GEN_CFG_RST, rdVal);
    rd(REG_SPREAD); chk("spread reset", SPREAD_CFG_RST, rdVal);
    rd(8'h55); chk("unmapped read", 8'h00, rdVal);
    wr(REG_SPREAD, 8'h07); rd(REG_SPREAD); chk("spread rw", 8'h07, rdVal);
    wr(REG_CABLE, 8'h00); rd(REG_CABLE); chk("cable ok", 1, rdVal[CABLE_OK_BIT]);
  endtask
  task automatic t_lock;
    txWord = GOOD;
    run = 1'b1;
    waitLock;
    chk("lock rise", 1, lockOut);
    chk("lock symbols", 1, c >= 28);
    tick(24);
    chk("pixel word", {PX, 3'h0}, pixOut);
  endtask
  task automatic t_edge;
    logic [23:0] pv [3];
    pv = '{PX, 24'ha1b2c3, PX};
    for (int e = 0; e < 2; e++) begin
      wr(REG_GEN_CFG, {6'h00, e[0], 1'b1});
      sendN({1'b1, pv[e+1], 3'h0, 6'h00, 1'b0}, 1, {1'b1, pv[e+1], 3'h0, 6'h00, 1'b0});
      c = 0;
      while (pixOut.red !== pv[e+1][23:16] && c < 60) begin
        tick(1);
        c++;
      end
      chk("strobe edge", e[0], pixClkOut);
      chk("green lag", pv[e][15:8], pixOut.green);
      tick(1);
      chk("green", pv[e+1][15:8], pixOut.green);
      chk("blue lag", pv[e][7:0], pixOut.blue);
      tick(1);
      chk("blue", pv[e+1][7:0], pixOut.blue);
    end
  endtask
  task automatic t_filter;
    pulse(2, 8'h03); chk("short pulse dropped", 0, s);
    pulse(3, 8'h03); chk("3-symbol pulse", 1, s);
    pulse(1, 8'h02); chk("unfiltered pulse", 1, s);
    wr(REG_GEN_CFG, 8'h03);
  endtask
  task automatic t_err;
    wr(REG_ERRCNT, 8'h00);
    sendN(BAD, 3, GOOD);
    tick(16);
    chk("lock lost", 0, lockOut);
    rd(REG_ERRCNT); chk("error count", 8'h03, rdVal);
    sendN(BAD, 30, GOOD);
    tick(16);
    rd(REG_ERRCNT); chk("error saturate", 8'h1f, rdVal);
    wr(REG_ERRCNT, 8'h00); rd(REG_ERRCNT); chk("error clear", 8'h00, rdVal);
    waitLock; chk("relock", 1, lockOut);
  endtask
  task automatic t_sleep;
    logic [4:0] b;
    run = 1'b0;
    tick(80);
    chk("sleep unlock", 0, lockOut);
    rd(REG_SPREAD); chk("kept in sleep", 8'h07, rdVal);
    run = 1'b1;
    c = 0;
    while (backTx !== 1'b1 && c < 100) begin
      tick(1);
      c++;
    end
    b = 5'h00;
    repeat (5) begin
      tick(1);
      b = {b[3:0], backTx};
    end
    chk("back frame", {gpioIn, 1'b1}, b);
    waitLock; chk("relock after sleep", 1, lockOut);
  endtask
  task automatic t_osc;
    run = 1'b0;
    tick(80);
    chk("clock idle", 0, pixClkOut);
    wr(REG_GEN_CFG, 8'h23);
    c = 0;
    while (pixClkOut !== 1'b1 && c < 50) begin
      tick(1);
      c++;
    end
    c = 0;
    while (pixClkOut === 1'b1 && c < 50) begin
      tick(1);
      c++;
    end
    chk("osc half period", 4, c);
    wr(REG_GEN_CFG, 8'h03);
    run = 1'b1;
    waitLock;
  endtask
  task automatic t_cable_pd;
    cableFault = 1'b1;
    tick(12); rd(REG_CABLE); chk("fault clears", 0, rdVal[CABLE_OK_BIT]);
    cableFault = 1'b0;
    tick(12); rd(REG_CABLE); chk("no fault", 1, rdVal[CABLE_OK_BIT]);
    powerDownN = 1'b0;
    tick(20);
    chk("pd lock", 0, lockOut);
    chk("pd pixels", 0, pixOut);
    rd(REG_SPREAD); chk("pd keeps regs", 8'h07, rdVal);
    powerDownN = 1'b1;
    waitLock; chk("lock after pd", 1, lockOut);
  endtask
  task automatic t_legacy;
    wr(REG_GEN_CFG, 8'h0b);
    sendN({7'h00, 1'b1, 24'h0f1e2d, 3'h0}, 1, {7'h00, 1'b1, 24'h0f1e2d, 3'h0});
    tick(40);
    waitLock;
    tick(24);
    chk("legacy pixel", {24'h0f1e2d, 3'h0}, pixOut);
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    sys_rst = 1'b1;
    powerDownN = 1'b1;
    cableFault = 1'b0;
    gpioIn = 4'ha;
    regAddr = 8'h00;
    regWe = 1'b0;
    regWrData = 8'h00;
    rdVal = 8'h00;
    run = 1'b0;
    txWord = GOOD;
    errCount = 0;
    nTests = 0;
    repeat (5) @(posedge mclk);
    #1 sys_rst = 1'b0;
    t_regs;
    t_lock;
    t_edge;
    t_filter;
    t_err;
    t_sleep;
    t_osc;
    t_cable_pd;
    t_legacy;
    conclude;
  end

  // Run needs about 4300 cycles; this allows over four times that
  initial begin
    #2_000_000;
    errCount++;
    conclude;
  end
endmodule
`default_nettype wire
